// ### common/tssc_pkg.sv
// Constants shared by the standby touch sampling block.
package tssc_pkg;

   // ------------------------------------------------------------
   // Register offsets
   // ------------------------------------------------------------
   localparam logic [7:0] ADDR_NOISE_THRESHOLD   = 8'h38;
   localparam logic [7:0] ADDR_INPUT_ENABLE      = 8'h40;
   localparam logic [7:0] ADDR_SAMPLING_CONFIG   = 8'h41;
   localparam logic [7:0] ADDR_SENSITIVITY       = 8'h42;
   localparam logic [7:0] ADDR_STANDBY_THRESHOLD = 8'h43;
   localparam logic [7:0] ADDR_TOUCH_STATUS      = 8'h44;

   // ------------------------------------------------------------
   // Values after reset
   // ------------------------------------------------------------
   localparam logic [7:0] RESET_INPUT_ENABLE    = 8'h00;
   localparam logic [7:0] RESET_SAMPLING_CONFIG = 8'h39;
   localparam logic [2:0] RESET_SENSITIVITY     = 3'h2;
   localparam logic [6:0] RESET_THRESHOLD       = 7'h40;
   localparam logic [1:0] RESET_NOISE_SELECT    = 2'h1;

   // ------------------------------------------------------------
   // Field positions in the sampling configuration and sensitivity registers
   // ------------------------------------------------------------
   localparam int CFG_ACCUMULATE_BIT = 7;
   localparam int CFG_COUNT_LSB      = 4;
   localparam int CFG_DURATION_LSB   = 2;
   localparam int CFG_PERIOD_LSB     = 0;
   localparam int SENSE_LSB          = 0;

   // ------------------------------------------------------------
   // Timing: a 5 us tick drives every slow count
   // ------------------------------------------------------------
   localparam int CLOCK_KHZ          = 40000;
   localparam int TICK_NS            = 5000;
   localparam int TICK_CYCLES        = TICK_NS * CLOCK_KHZ / 1000000;
   localparam int SAMPLE_UNIT_US     = 320;
   localparam int CYCLE_UNIT_MS      = 35;
   localparam logic [9:0] SAMPLE_UNIT_TICKS =
      10'(SAMPLE_UNIT_US * 1000 / TICK_NS);
   localparam logic [23:0] CYCLE_UNIT_TICKS =
      24'(CYCLE_UNIT_MS * 1000000 / TICK_NS);

   // ------------------------------------------------------------
   // Sequencer states
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_SCAN,
      ST_SAMPLE,
      ST_FINISH
   } tssc_state_t;

endpackage : tssc_pkg

// ### hw/tssc_accum.sv
// Sample accumulator with average or sum and sensitivity scaling.
`timescale 1ns/1ps
module tssc_accum
   import tssc_pkg::*;
#(
   parameter int SAMPLE_W = 16
) (
   // Clock and reset
   input  wire logic                clk_in,
   input  wire logic                reset_in,
   // Accumulation control
   input  wire logic                clear_in,
   input  wire logic                add_in,
   input  wire logic [SAMPLE_W-1:0] value_in,
   // Mode settings
   input  wire logic [2:0]          count_code_in,
   input  wire logic                sum_mode_in,
   input  wire logic [2:0]          gain_code_in,
   // Scaled delta count
   output logic      [7:0]          delta_out
);

   localparam int SUM_W = SAMPLE_W + 7;

   logic [SUM_W-1:0] sum;
   logic [SUM_W-1:0] average;
   logic [SUM_W-1:0] chosen;
   logic [SUM_W:0]   doubled;
   logic [SUM_W:0]   scaled;

   // ------------------------------------------------------------
   // Running sum
   // ------------------------------------------------------------
   // Room for 128 full-scale samples, so the sum never wraps.
   always_ff @(posedge clk_in) begin
      if (reset_in || clear_in) begin
         sum <= '0;
      end else if (add_in) begin
         sum <= sum + SUM_W'(value_in);
      end
   end

   // ------------------------------------------------------------
   // Average or sum, then gain
   // ------------------------------------------------------------
   // Count is a power of two, so the average is a plain shift.
   assign average = sum >> count_code_in;
   assign chosen  = sum_mode_in ? sum : average;
   // One raw count is two delta units at 128x, halving per step.
   assign doubled = {chosen, 1'b0};
   assign scaled  = doubled >> gain_code_in;
   // Saturate: a big sum in accumulate mode pins at full scale.
   assign delta_out = (|scaled[SUM_W:8]) ? 8'hFF : scaled[7:0];

endmodule : tssc_accum

// ### hw/tssc_top.sv
// Standby touch sampling configuration and sequencer.
`timescale 1ns/1ps
module tssc_top
   import tssc_pkg::*;
#(
   parameter int SAMPLE_W    = 16,
   parameter int TICK_PERIOD = TICK_CYCLES
) (
   // Clock and reset
   input  wire logic                clk_in,
   input  wire logic                reset_in,
   // Register port
   input  wire logic [7:0]          reg_addr_in,
   input  wire logic                reg_wr_in,
   input  wire logic [7:0]          reg_wdata_in,
   input  wire logic                reg_rd_in,
   output logic      [7:0]          reg_rdata_out,
   // Power state
   input  wire logic                standby_en_in,
   output logic                     low_power_out,
   // Analog front end
   input  wire logic [SAMPLE_W-1:0] sample_delta_in,
   output logic                     sample_active_out,
   output logic      [2:0]          sample_input_out,
   // Results
   output logic                     result_valid_out,
   output logic      [2:0]          result_input_out,
   output logic      [7:0]          result_delta_out,
   output logic      [7:0]          touch_status_out,
   output logic      [7:0]          noise_flag_out
);

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   logic [7:0] input_enable;
   logic [7:0] sampling_config;
   logic [2:0] standby_gain_select;
   logic [6:0] standby_threshold;
   logic [1:0] noise_threshold_select;

   logic accumulate_mode;
   logic [2:0] standby_sample_count;
   logic [1:0] standby_sample_duration;
   logic [1:0] standby_cycle_period;

   // Field split of the configuration register.
   assign accumulate_mode         = sampling_config[CFG_ACCUMULATE_BIT];
   assign standby_sample_count    = sampling_config[CFG_COUNT_LSB+:3];
   assign standby_sample_duration = sampling_config[CFG_DURATION_LSB+:2];
   assign standby_cycle_period    = sampling_config[CFG_PERIOD_LSB+:2];

   // Write strobes decoded from the address.
   logic wr_enable;
   logic wr_config;
   logic wr_gain;
   logic wr_thresh;
   logic wr_noise;
   assign wr_enable = reg_wr_in && (reg_addr_in == ADDR_INPUT_ENABLE);
   assign wr_config = reg_wr_in && (reg_addr_in == ADDR_SAMPLING_CONFIG);
   assign wr_gain   = reg_wr_in && (reg_addr_in == ADDR_SENSITIVITY);
   assign wr_thresh = reg_wr_in && (reg_addr_in == ADDR_STANDBY_THRESHOLD);
   assign wr_noise  = reg_wr_in && (reg_addr_in == ADDR_NOISE_THRESHOLD);

   // Register writes; only the defined bits are stored.
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         input_enable           <= RESET_INPUT_ENABLE;
         sampling_config        <= RESET_SAMPLING_CONFIG;
         standby_gain_select    <= RESET_SENSITIVITY;
         standby_threshold      <= RESET_THRESHOLD;
         noise_threshold_select <= RESET_NOISE_SELECT;
      end else begin
         if (wr_enable) input_enable <= reg_wdata_in;
         if (wr_config) sampling_config <= reg_wdata_in;
         if (wr_gain) standby_gain_select <= reg_wdata_in[SENSE_LSB+:3];
         if (wr_thresh) standby_threshold <= reg_wdata_in[6:0];
         if (wr_noise) noise_threshold_select <= reg_wdata_in[1:0];
      end
   end

   // Read selection; unmapped offsets read zero.
   logic [7:0] read_mux;
   assign read_mux =
      (reg_addr_in == ADDR_INPUT_ENABLE)      ? input_enable :
      (reg_addr_in == ADDR_SAMPLING_CONFIG)   ? sampling_config :
      (reg_addr_in == ADDR_SENSITIVITY)       ? {5'h00, standby_gain_select} :
      (reg_addr_in == ADDR_STANDBY_THRESHOLD) ? {1'b0, standby_threshold} :
      (reg_addr_in == ADDR_NOISE_THRESHOLD)   ?
         {6'h00, noise_threshold_select} :
      (reg_addr_in == ADDR_TOUCH_STATUS)      ? touch_status_out :
      8'h00;

   // Read data is captured one cycle after the read strobe.
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         reg_rdata_out <= 8'h00;
      end else if (reg_rd_in) begin
         reg_rdata_out <= read_mux;
      end
   end

   // ------------------------------------------------------------
   // Tick divider
   // ------------------------------------------------------------
   logic [15:0] div_cnt;
   logic        tick;
   assign tick = (div_cnt == 16'(TICK_PERIOD - 1));

   always_ff @(posedge clk_in) begin
      if (reset_in || tick) begin
         div_cnt <= 16'h0000;
      end else begin
         div_cnt <= div_cnt + 16'h0001;
      end
   end

   // ------------------------------------------------------------
   // Timing decode
   // ------------------------------------------------------------
   logic [9:0]  sample_ticks;
   logic [23:0] cycle_ticks;
   logic [7:0]  sample_total;
   assign sample_ticks = SAMPLE_UNIT_TICKS << standby_sample_duration;
   assign cycle_ticks  = CYCLE_UNIT_TICKS * {22'h000000,
                         standby_cycle_period} + CYCLE_UNIT_TICKS;
   assign sample_total = 8'h01 << standby_sample_count;

   // ------------------------------------------------------------
   // Sequencer
   // ------------------------------------------------------------
   tssc_state_t state;
   logic [2:0]  idx;
   logic [9:0]  win_cnt;
   logic [7:0]  samp_cnt;
   logic [23:0] cyc_cnt;

   logic win_last;
   logic samp_last;
   logic add_sample;
   logic cycle_due;
   logic last_input;
   assign win_last   = tick && (win_cnt == sample_ticks - 10'h001);
   assign samp_last  = (samp_cnt == sample_total - 8'h01);
   assign add_sample = (state == ST_SAMPLE) && win_last;
   // A cycle that outlasted its period restarts at once.
   assign cycle_due  = (cyc_cnt >= cycle_ticks);
   assign last_input = (idx == 3'h7);

   // Cycle timer counts ticks since the cycle started, saturating.
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         cyc_cnt <= 24'hFFFFFF;
      end else if (state == ST_IDLE && standby_en_in && cycle_due) begin
         cyc_cnt <= 24'h000000;
      end else if (tick && cyc_cnt != 24'hFFFFFF) begin
         cyc_cnt <= cyc_cnt + 24'h000001;
      end
   end

   // Main sequence: scan inputs, sample each enabled one back to back, then idle.
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         state    <= ST_IDLE;
         idx      <= 3'h0;
         win_cnt  <= 10'h000;
         samp_cnt <= 8'h00;
      end else begin
         unique case (state)
            ST_IDLE: begin
               if (standby_en_in && cycle_due) begin
                  idx   <= 3'h0;
                  state <= ST_SCAN;
               end
            end
            ST_SCAN: begin
               win_cnt  <= 10'h000;
               samp_cnt <= 8'h00;
               if (input_enable[idx]) begin
                  state <= ST_SAMPLE;
               end else if (last_input) begin
                  state <= ST_IDLE;
               end else begin
                  idx <= idx + 3'h1;
               end
            end
            ST_SAMPLE: begin
               if (win_last) begin
                  win_cnt <= 10'h000;
                  if (samp_last) begin
                     state <= ST_FINISH;
                  end else begin
                     samp_cnt <= samp_cnt + 8'h01;
                  end
               end else if (tick) begin
                  win_cnt <= win_cnt + 10'h001;
               end
            end
            ST_FINISH: begin
               if (last_input) begin
                  state <= ST_IDLE;
               end else begin
                  idx   <= idx + 3'h1;
                  state <= ST_SCAN;
               end
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // Accumulation and classification
   // ------------------------------------------------------------
   logic [7:0] delta;
   logic [9:0] noise_product;
   logic [7:0] noise_level;
   logic       is_touch;
   logic       is_noise;

   tssc_accum #(
      .SAMPLE_W (SAMPLE_W)
   ) u_accum (
      .clk_in        (clk_in),
      .reset_in      (reset_in),
      .clear_in      (state == ST_SCAN),
      .add_in        (add_sample),
      .value_in      (sample_delta_in),
      .count_code_in (standby_sample_count),
      .sum_mode_in   (accumulate_mode),
      .gain_code_in  (standby_gain_select),
      .delta_out     (delta)
   );

   // Noise level is 25 to 62.5 percent of the touch threshold.
   assign noise_product = {3'h0, standby_threshold} *
                          {8'h00, noise_threshold_select + 2'h0} +
                          {2'h0, standby_threshold, 1'b0};
   assign noise_level = {3'h0, noise_product[9:5]} +
                        {1'b0, noise_product[9:3]} - {3'h0, noise_product[9:5]};
   assign is_touch = (delta > {1'b0, standby_threshold});
   assign is_noise = !is_touch && (delta > noise_level);

   // Result strobe, plus result data and per-input status held until the next measurement.
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         result_valid_out  <= 1'b0;
         result_input_out  <= 3'h0;
         result_delta_out  <= 8'h00;
         touch_status_out  <= 8'h00;
         noise_flag_out    <= 8'h00;
         sample_active_out <= 1'b0;
         sample_input_out  <= 3'h0;
         low_power_out     <= 1'b0;
      end else begin
         result_valid_out  <= (state == ST_FINISH);
         sample_active_out <= (state == ST_SAMPLE) && !(win_last && samp_last);
         sample_input_out  <= idx;
         low_power_out     <= (state == ST_IDLE) &&
                              !(standby_en_in && cycle_due);
         if (state == ST_FINISH) begin
            result_input_out      <= idx;
            result_delta_out      <= delta;
            touch_status_out[idx] <= is_touch;
            noise_flag_out[idx]   <= is_noise;
         end
      end
   end

endmodule : tssc_top

// ### verification/tssc_front_model.sv
// Behavioural analog front end returning a fixed raw delta per input.
`timescale 1ns/1ps
module tssc_front_model (
   // Clock
   input  wire logic        clk_in,
   // Sample window from the block, levels from the bench
   input  wire logic        sample_active_in,
   input  wire logic [2:0]  sample_input_in,
   input  wire logic [15:0] level_in [8],
   // Raw delta to the block
   output logic      [15:0] sample_delta_out
);
   logic toggle = 1'b0;

   // Outside a window the pads carry nothing useful.
   // A moving pattern keeps a stale value from being latched by mistake.
   // A plain process, since the variable also carries a start value.
   always @(posedge clk_in) begin
      toggle <= ~toggle;
   end
   assign sample_delta_out = sample_active_in ?
      level_in[sample_input_in] : {8{toggle, ~toggle}};
endmodule : tssc_front_model

// ### verification/tssc_checker_assertions.sv
// Port-level assertions for the standby touch sampling block.
`timescale 1ns/1ps
module tssc_checker
   import tssc_pkg::*;
#(
   parameter int SAMPLE_W    = 16,
   parameter int TICK_PERIOD = TICK_CYCLES
) (
   // Clock and reset
   input  wire logic                clk_in,
   input  wire logic                reset_in,
   // Register port
   input  wire logic [7:0]          reg_addr_in,
   input  wire logic                reg_wr_in,
   input  wire logic [7:0]          reg_wdata_in,
   input  wire logic                reg_rd_in,
   input  wire logic [7:0]          reg_rdata_out,
   // Power state
   input  wire logic                standby_en_in,
   input  wire logic                low_power_out,
   // Analog front end
   input  wire logic [SAMPLE_W-1:0] sample_delta_in,
   input  wire logic                sample_active_out,
   input  wire logic [2:0]          sample_input_out,
   // Results
   input  wire logic                result_valid_out,
   input  wire logic [2:0]          result_input_out,
   input  wire logic [7:0]          result_delta_out,
   input  wire logic [7:0]          touch_status_out,
   input  wire logic [7:0]          noise_flag_out
);
   localparam int LP_MAX = 4 * int'(CYCLE_UNIT_TICKS) * TICK_PERIOD;
   logic [7:0] en_copy;
   logic [7:0] cfg_copy;
   logic [6:0] thr_copy;
   logic [2:0] last_in;
   int         lp_cnt;

   default clocking @(posedge clk_in); endclocking
   default disable iff (reset_in);

   // Shadow copies of the enable, config and threshold registers, and an idle span counter.
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         en_copy  <= RESET_INPUT_ENABLE;
         cfg_copy <= RESET_SAMPLING_CONFIG;
         thr_copy <= RESET_THRESHOLD;
         last_in  <= 3'h0;
         lp_cnt   <= 0;
      end else begin
         if (reg_wr_in && reg_addr_in == ADDR_INPUT_ENABLE) begin
            en_copy <= reg_wdata_in;
         end
         if (reg_wr_in && reg_addr_in == ADDR_SAMPLING_CONFIG) begin
            cfg_copy <= reg_wdata_in;
         end
         if (reg_wr_in && reg_addr_in == ADDR_STANDBY_THRESHOLD) begin
            thr_copy <= reg_wdata_in[6:0];
         end
         if (sample_active_out) begin
            last_in <= sample_input_out;
         end
         lp_cnt <= (low_power_out && standby_en_in) ? lp_cnt + 1 : 0;
      end
   end

   // Register port, sequencing and result checks against the shadows.
   rd_reserved_a: assert property (
      reg_rd_in && reg_addr_in == ADDR_SENSITIVITY
      |=> reg_rdata_out[7:3] == 5'h00)
      else $error("gain upper bits set");
   rdata_hold_a: assert property (
      !reg_rd_in |=> $stable(reg_rdata_out))
      else $error("read data moved without a read");
   cfg_readback_a: assert property (
      reg_rd_in && reg_addr_in == ADDR_SAMPLING_CONFIG
      |=> reg_rdata_out == cfg_copy)
      else $error("config readback wrong");
   sample_enabled_a: assert property (
      sample_active_out |-> en_copy[sample_input_out])
      else $error("disabled input sampled");
   idle_quiet_a: assert property (
      low_power_out |-> !sample_active_out)
      else $error("sampling while in low power");
   result_input_a: assert property (
      result_valid_out |-> result_input_out == last_in)
      else $error("result for wrong input");
   touch_judge_a: assert property (
      result_valid_out |-> touch_status_out[result_input_out]
         == (result_delta_out > {1'b0, thr_copy}))
      else $error("touch decision wrong");
   input_steady_a: assert property (
      sample_active_out && $past(sample_active_out)
      |-> $stable(sample_input_out))
      else $error("input changed inside a window");
   idle_bound_a: assert property (
      lp_cnt <= LP_MAX)
      else $error("idle outlasts longest cycle");

   cover property (result_valid_out && touch_status_out != 8'h00);
   cover property ($rose(low_power_out));
   cover property (reg_rd_in && reg_addr_in == ADDR_SENSITIVITY);
endmodule : tssc_checker

// ### verification/tb.sv
// Self-checking bench for the standby touch sampling block.
`timescale 1ns/1ps
module tb;
   import tssc_pkg::*;
   localparam int TP = 2;
   logic        clk_in, reset_in, reg_wr_in, reg_rd_in, standby_en_in;
   logic [7:0]  reg_addr_in, reg_wdata_in, reg_rdata_out;
   logic        low_power_out, sample_active_out, result_valid_out;
   logic [2:0]  sample_input_out, result_input_out;
   logic [7:0]  result_delta_out, touch_status_out, noise_flag_out;
   logic [15:0] sample_delta_in;
   logic [15:0] level [8];
   int          err_count = 0;
   int          cmp_count = 0;

   // Short tick keeps the millisecond counts affordable in simulation.
   tssc_top #(.TICK_PERIOD(TP)) i_dut (.clk_in, .reset_in, .reg_addr_in,
      .reg_wr_in, .reg_wdata_in, .reg_rd_in, .reg_rdata_out, .standby_en_in,
      .low_power_out, .sample_delta_in, .sample_active_out, .sample_input_out,
      .result_valid_out, .result_input_out, .result_delta_out,
      .touch_status_out, .noise_flag_out);
   tssc_front_model i_front (.clk_in, .sample_active_in(sample_active_out),
      .sample_input_in(sample_input_out), .level_in(level),
      .sample_delta_out(sample_delta_in));

   // ------------------------------------------------------------
   // Bus cycles and comparisons
   // ------------------------------------------------------------
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_in);
      reg_addr_in  <= a;
      reg_wdata_in <= d;
      reg_wr_in    <= 1'b1;
      @(posedge clk_in);
      reg_wr_in <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_in);
      reg_addr_in <= a;
      reg_rd_in   <= 1'b1;
      @(posedge clk_in);
      reg_rd_in <= 1'b0;
      #1 d = reg_rdata_out;
   endtask : rd
   task automatic stby(input logic v);
      @(posedge clk_in);
      standby_en_in <= v;
   endtask : stby
   // Bounded wait for the next finished measurement; t counts its cycles.
   task automatic get_res(output logic [2:0] i, output logic [7:0] d,
                          output int t);
      t = 0;
      do begin
         @(posedge clk_in);
         #1 t++;
      end while (result_valid_out !== 1'b1 && t < 40000);
      // A missing result is a mismatch, never a silent stale read.
      if (result_valid_out !== 1'b1) begin
         err_count++;
         $display("BAD result_valid expected 1 seen timeout");
      end
      i = result_input_out;
      d = result_delta_out;
   endtask : get_res
   task automatic wait_lp;
      int n;
      n = 0;
      while (low_power_out !== 1'b1 && n < 40000) begin
         @(posedge clk_in);
         #1 n++;
      end
      if (low_power_out !== 1'b1) begin
         err_count++;
         $display("BAD low_power expected 1 seen timeout");
      end
   endtask : wait_lp
   task automatic check(input string nm, input logic [31:0] e,
                        input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         err_count++;
         $display("BAD %s expected %0h seen %0h", nm, e, g);
      end
   endtask : check
   task automatic check_in(input string nm, input int lo, input int hi,
                           input int g);
      cmp_count++;
      if (g < lo || g > hi) begin
         err_count++;
         $display("BAD %s expected %0d..%0d seen %0d", nm, lo, hi, g);
      end
   endtask : check_in

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_reset;
      logic [7:0] d;
      rd(ADDR_INPUT_ENABLE, d);
      check("enable", 8'h00, d);
      rd(ADDR_SAMPLING_CONFIG, d);
      check("config", 8'h39, d);
      rd(ADDR_SENSITIVITY, d);
      check("gain", 8'h02, d);
      rd(8'h50, d);
      check("unmapped", 8'h00, d);
   endtask : t_reset
   task automatic t_reserved;
      logic [7:0] d;
      wr(ADDR_SENSITIVITY, 8'hFF);
      rd(ADDR_SENSITIVITY, d);
      check("gain upper", 8'h07, d);
   endtask : t_reserved
   // Average of two samples at 128x, inputs one and eight, 35 ms cycle.
   task automatic t_average;
      logic [2:0] i;
      logic [7:0] d;
      int a, b;
      level[0] = 16'h0014;
      level[7] = 16'h0064;
      wr(ADDR_INPUT_ENABLE, 8'h81);
      wr(ADDR_SAMPLING_CONFIG, 8'h10);
      wr(ADDR_SENSITIVITY, 8'h00);
      stby(1'b1);
      get_res(i, d, a);
      check("first input", 3'h0, i);
      check("avg delta", 8'h28, d);
      get_res(i, d, a);
      check("second input", 3'h7, i);
      check("x128 delta", 8'hC8, d);
      check("touch", 8'h80, touch_status_out);
      check("noise", 8'h01, noise_flag_out);
      get_res(i, d, b);
      check_in("cycle", 13998, 14002, a + b);
      wait_lp;
      stby(1'b0);
   endtask : t_average
   // Sum of two samples at 1x, input one only.
   task automatic t_sum;
      logic [2:0] i;
      logic [7:0] d;
      int a;
      level[0] = 16'h0280;
      wr(ADDR_INPUT_ENABLE, 8'h01);
      wr(ADDR_SAMPLING_CONFIG, 8'h90);
      wr(ADDR_SENSITIVITY, 8'h07);
      stby(1'b1);
      get_res(i, d, a);
      check("sum input", 3'h0, i);
      check("sum delta", 8'h14, d);
      wait_lp;
      stby(1'b0);
   endtask : t_sum
   // Eight 2.56 ms samples on two inputs outlast a 35 ms cycle.
   // Gain drops to 16x while input eight samples, so its delta halves thrice.
   task automatic t_stretch;
      logic [2:0] i;
      logic [7:0] d;
      int a, b;
      level[0] = 16'h0014;
      wr(ADDR_INPUT_ENABLE, 8'h81);
      wr(ADDR_SAMPLING_CONFIG, 8'h3C);
      wr(ADDR_SENSITIVITY, 8'h00);
      stby(1'b1);
      get_res(i, d, a);
      check("avg of eight", 8'h28, d);
      wr(ADDR_SENSITIVITY, 8'h03);
      get_res(i, d, a);
      check("x16 delta", 8'h19, d);
      get_res(i, d, b);
      check_in("stretch", 16384, 16584, a + b);
   endtask : t_stretch

   task automatic give_verdict;
      $display("Comparisons %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : give_verdict

   // Clock, main sequence and watchdog.
   initial begin
      clk_in = 1'b0;
      forever #12.5 clk_in = ~clk_in;
   end
   initial begin
      reset_in      = 1'b1;
      reg_wr_in     = 1'b0;
      reg_rd_in     = 1'b0;
      standby_en_in = 1'b0;
      reg_addr_in   = 8'h00;
      reg_wdata_in  = 8'h00;
      for (int k = 0; k < 8; k++) level[k] = 16'h0000;
      repeat (4) @(posedge clk_in);
      reset_in <= 1'b0;
      t_reset;
      t_reserved;
      t_average;
      t_sum;
      t_stretch;
      give_verdict;
   end
   initial begin
      repeat (100000) @(posedge clk_in);
      err_count++;
      give_verdict;
   end
endmodule : tb

bind tssc_top tssc_checker #(.SAMPLE_W(SAMPLE_W), .TICK_PERIOD(TICK_PERIOD))
   i_chk (.clk_in, .reset_in, .reg_addr_in, .reg_wr_in, .reg_wdata_in,
   .reg_rd_in, .reg_rdata_out, .standby_en_in, .low_power_out,
   .sample_delta_in, .sample_active_out, .sample_input_out,
   .result_valid_out, .result_input_out, .result_delta_out,
   .touch_status_out, .noise_flag_out);
